/* File: hdl/adclp_top.sv */
// converter control: registers, triggers, low-power states and result handling
// Overview of operation
// - shallow stop without async clock aborts conversion
// - shallow stop leaves result registers unchanged
// - after such stop, idle until new trigger
// - async clock selected: conversion runs through stop
// - in stop, only hardware starts or continuous and blocked-result restarts
// - completion sets flag, interrupt when enabled
// - deep stop disables, registers return to reset
// - config bits: low power, divider, long sample
// - config bits: resolution and input clock source
// - control two: active, trigger, compare enable, direction
// - control two bits 3:0 read zero
// - control one: flag, interrupt enable, continuous
// - control one bits 4:0 select channel
// - high byte read first protects result pair
// - compare registers hold the threshold
// - pin control bits disable digital pin I/O
// - control one write aborts, restarts under software trigger unless channel off
// - blocked result lost, flag not set by it
`timescale 1ns/1ps
`default_nettype none
module adclp_top (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic STOP_SHALLOW,
	input wire logic STOP_DEEP,
	input wire logic HW_TRIGGER,
	input wire logic [9:0] ANALOG_CODE,
	output logic CONV_IRQ,
	output logic CONV_ACTIVE,
	output logic [4:0] CHANNEL_SEL,
	output logic LOW_POWER,
	output logic [15:0] PIN_IO_DISABLE
);
	import adclp_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	adclp_state_type state_ff;
	adclp_state_type nxt_state;
	logic [7:0] config_register_ff;
	logic hw_trigger_sel_ff;
	logic compare_enable_ff;
	logic compare_greater_sel_ff;
	logic conv_complete_flag_ff;
	logic conv_irq_enable_ff;
	logic continuous_sel_ff;
	logic [4:0] channel_sel_ff;
	logic [9:0] result_ff;
	logic [9:0] compare_value_ff;
	logic [7:0] pin_ctrl_one_ff;
	logic [7:0] pin_ctrl_two_ff;
	logic high_read_ff;
	logic stop_prev_ff;
	logic trig_prev_ff;
	logic wr_en_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic irq_ff;
	logic active_ff;

	// ---------------------------------------------------------------
	// decode wires
	// ---------------------------------------------------------------
	logic rst_all;
	logic take;
	logic rd_take, rd_res_high, rd_res_low;
	logic wr_cfg, wr_ct2, wr_ct1, wr_cvh, wr_cvl, wr_pin1, wr_pin2;
	logic [7:0] rd_byte;
	logic async_sel;
	logic ten_bit;
	logic stop_rise, stop_fall, trig_rise;
	logic stop_abort, cfg_abort, abort_all;
	logic sw_start, hw_start, restart, seq_start;
	logic seq_busy;
	logic seq_done;
	logic [9:0] raw_code, cmp_code, diff_code;
	logic cmp_true;
	logic blocked;
	logic terminate;
	logic xfer;
	logic flag_clear;
	logic nxt_flag;
	logic nxt_high_read;
	logic [9:0] nxt_result;
	logic [31:0] nxt_hrdata;

	// deep stop holds everything in its reset state
	assign rst_all = RESET | STOP_DEEP;

	// ---------------------------------------------------------------
	// bus slave decode
	// ---------------------------------------------------------------
	assign take = HSEL & HTRANS[1] & HREADY;
	assign rd_take = take & ~HWRITE;
	assign rd_res_high = rd_take & (HADDR[7:0] == OFS_RES_HIGH);
	assign rd_res_low = rd_take & (HADDR[7:0] == OFS_RES_LOW);
	assign wr_cfg = wr_en_ff & (wr_addr_ff == OFS_CONFIG);
	assign wr_ct2 = wr_en_ff & (wr_addr_ff == OFS_CTRL_TWO);
	assign wr_ct1 = wr_en_ff & (wr_addr_ff == OFS_CTRL_ONE);
	assign wr_cvh = wr_en_ff & (wr_addr_ff == OFS_CMP_HIGH);
	assign wr_cvl = wr_en_ff & (wr_addr_ff == OFS_CMP_LOW);
	assign wr_pin1 = wr_en_ff & (wr_addr_ff == OFS_PIN_ONE);
	assign wr_pin2 = wr_en_ff & (wr_addr_ff == OFS_PIN_TWO);

	// read multiplexer, unmapped offsets read zero
	always_comb begin
		case (HADDR[7:0])
			OFS_CONFIG: rd_byte = config_register_ff;
			OFS_CTRL_TWO: rd_byte = {seq_busy, hw_trigger_sel_ff, compare_enable_ff,
				compare_greater_sel_ff, 4'h0};
			OFS_CTRL_ONE: rd_byte = {conv_complete_flag_ff, conv_irq_enable_ff,
				continuous_sel_ff, channel_sel_ff};
			OFS_RES_HIGH: rd_byte = ten_bit ? {6'h00, result_ff[9:8]} : 8'h00;
			OFS_RES_LOW: rd_byte = result_ff[7:0];
			OFS_CMP_HIGH: rd_byte = {6'h00, compare_value_ff[9:8]};
			OFS_CMP_LOW: rd_byte = compare_value_ff[7:0];
			OFS_PIN_ONE: rd_byte = pin_ctrl_one_ff;
			OFS_PIN_TWO: rd_byte = pin_ctrl_two_ff;
			default: rd_byte = 8'h00;
		endcase
	end
	assign nxt_hrdata = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

	// ---------------------------------------------------------------
	// configuration fields
	// ---------------------------------------------------------------
	assign async_sel = config_register_ff[CFG_CLK_LSB +: 2] == CLK_ASYNC;
	assign ten_bit = config_register_ff[CFG_MODE_LSB +: 2] == MODE_TEN;

	// ---------------------------------------------------------------
	// low-power state and trigger edges
	// ---------------------------------------------------------------
	assign stop_rise = STOP_SHALLOW & ~stop_prev_ff;
	assign stop_fall = ~STOP_SHALLOW & stop_prev_ff;
	assign trig_rise = HW_TRIGGER & ~trig_prev_ff;
	assign stop_abort = stop_rise & ~async_sel;

	// any mode change invalidates the running conversion
	assign cfg_abort = wr_cfg | wr_ct2 | wr_cvh | wr_cvl;
	assign abort_all = cfg_abort | wr_ct1 | stop_abort;

	// ---------------------------------------------------------------
	// conversion starts
	// ---------------------------------------------------------------
	// software start needs the processor running and a live channel
	assign sw_start = wr_ct1 & (HWDATA[4:0] != CH_OFF) & ~hw_trigger_sel_ff
		& ~STOP_SHALLOW;
	// hardware start while idle; in stop only with the async clock
	assign hw_start = hw_trigger_sel_ff & trig_rise & (state_ff == ST_IDLE)
		& (~STOP_SHALLOW | async_sel) & ~abort_all;

	// ---------------------------------------------------------------
	// compare and blocking
	// ---------------------------------------------------------------
	assign raw_code = ten_bit ? ANALOG_CODE : {2'b00, ANALOG_CODE[9:2]};
	assign cmp_code = ten_bit ? compare_value_ff : {2'b00, compare_value_ff[7:0]};
	assign diff_code = raw_code - cmp_code;
	assign cmp_true = compare_greater_sel_ff ? (raw_code >= cmp_code)
		: (raw_code < cmp_code);
	assign blocked = high_read_ff & ten_bit;
	assign terminate = ~continuous_sel_ff & compare_enable_ff & ~cmp_true;
	assign xfer = seq_done & (~compare_enable_ff | cmp_true) & ~blocked;
	// continuous mode, or a blocked result that is not a failed single compare
	assign restart = seq_done & ~abort_all
		& (continuous_sel_ff | (blocked & ~terminate));
	assign seq_start = sw_start | hw_start | restart;

	// ---------------------------------------------------------------
	// next values
	// ---------------------------------------------------------------
	// flag set wins over the clear by a control write or low-byte read
	assign flag_clear = wr_ct1 | rd_res_low;
	assign nxt_flag = xfer ? 1'b1 : (flag_clear ? 1'b0 : conv_complete_flag_ff);
	assign nxt_high_read = (rd_res_high & ten_bit) ? 1'b1
		: (rd_res_low ? 1'b0 : high_read_ff);
	// results change only on a completed transfer or deep stop reset, never on shallow stop or abort
	assign nxt_result = xfer ? (compare_enable_ff ? diff_code : raw_code)
		: result_ff;

	// converter state machine
	always_comb begin
		case (state_ff)
			ST_IDLE: nxt_state = seq_start ? ST_CONVERT : ST_IDLE;
			ST_CONVERT: begin
				if (seq_start) begin
					nxt_state = ST_CONVERT;
				end else if (abort_all | seq_done) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_CONVERT;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// conversion duration counter
	// ---------------------------------------------------------------
	adclp_seq u_seq (
		.clk(CLK),
		.rst(rst_all),
		.start(seq_start),
		.abort(abort_all),
		.long_sample(config_register_ff[CFG_LONG_BIT]),
		.ten_bit(ten_bit),
		.div(config_register_ff[CFG_DIV_LSB +: 2]),
		.busy(seq_busy),
		.done(seq_done)
	);

	// ---------------------------------------------------------------
	// bus and edge registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			wr_en_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b1;
			stop_prev_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else begin
			wr_en_ff <= take & HWRITE;
			wr_addr_ff <= HADDR[7:0];
			hrdata_ff <= nxt_hrdata;
			hreadyout_ff <= 1'b1;
			stop_prev_ff <= STOP_SHALLOW;
			trig_prev_ff <= HW_TRIGGER;
		end
	end

	// software registers, written in the data phase
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			config_register_ff <= RST_BYTE;
			hw_trigger_sel_ff <= 1'b0;
			compare_enable_ff <= 1'b0;
			compare_greater_sel_ff <= 1'b0;
			conv_irq_enable_ff <= 1'b0;
			continuous_sel_ff <= 1'b0;
			channel_sel_ff <= CH_OFF;
			compare_value_ff <= RST_WORD;
			pin_ctrl_one_ff <= RST_BYTE;
			pin_ctrl_two_ff <= RST_BYTE;
		end else begin
			if (wr_cfg) begin
				config_register_ff <= HWDATA[7:0];
			end
			if (wr_ct2) begin
				hw_trigger_sel_ff <= HWDATA[CT2_TRIG_BIT];
				compare_enable_ff <= HWDATA[CT2_CMP_EN_BIT];
				compare_greater_sel_ff <= HWDATA[CT2_CMP_GT_BIT];
			end
			if (wr_ct1) begin
				conv_irq_enable_ff <= HWDATA[CT1_IRQ_BIT];
				continuous_sel_ff <= HWDATA[CT1_CONT_BIT];
				channel_sel_ff <= HWDATA[CT1_CH_LSB +: 5];
			end
			if (wr_cvh) begin
				compare_value_ff[9:8] <= HWDATA[1:0];
			end
			if (wr_cvl) begin
				compare_value_ff[7:0] <= HWDATA[7:0];
			end
			if (wr_pin1) begin
				pin_ctrl_one_ff <= HWDATA[7:0];
			end
			if (wr_pin2) begin
				pin_ctrl_two_ff <= HWDATA[7:0];
			end
		end
	end

	// hardware state registers
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			state_ff <= ST_IDLE;
			conv_complete_flag_ff <= 1'b0;
			high_read_ff <= 1'b0;
			result_ff <= RST_WORD;
			irq_ff <= 1'b0;
			active_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			conv_complete_flag_ff <= nxt_flag;
			high_read_ff <= nxt_high_read;
			result_ff <= nxt_result;
			irq_ff <= nxt_flag & conv_irq_enable_ff;
			active_ff <= nxt_state == ST_CONVERT;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign HRDATA = hrdata_ff;
	assign HREADYOUT = hreadyout_ff;
	assign HRESP = 1'b0;
	assign CONV_IRQ = irq_ff;
	assign CONV_ACTIVE = active_ff;
	assign CHANNEL_SEL = channel_sel_ff;
	assign LOW_POWER = config_register_ff[CFG_LOW_POWER_BIT];
	assign PIN_IO_DISABLE = {pin_ctrl_two_ff, pin_ctrl_one_ff};

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	stop_abort_a: assert property (@(posedge CLK) disable iff (rst_all)
		stop_rise && !async_sel |=> state_ff == ST_IDLE && !seq_busy)
		else $error("shallow stop did not abort conversion");
	result_hold_a: assert property (@(posedge CLK) disable iff (rst_all)
		(stop_rise || stop_fall) && !xfer |=> result_ff == $past(result_ff))
		else $error("result changed on stop transition");
	idle_stay_a: assert property (@(posedge CLK) disable iff (rst_all)
		state_ff == ST_IDLE && !sw_start && !hw_start |=> state_ff == ST_IDLE)
		else $error("converter left idle without trigger");
	async_run_a: assert property (@(posedge CLK) disable iff (rst_all)
		stop_rise && async_sel && seq_busy && !seq_done && !abort_all
		|=> state_ff == ST_CONVERT)
		else $error("conversion stopped in stop with async clock");
	stop_start_a: assert property (@(posedge CLK) disable iff (rst_all)
		STOP_SHALLOW && wr_ct1 |=> !seq_busy)
		else $error("software start during shallow stop");
	flag_irq_a: assert property (@(posedge CLK) disable iff (rst_all)
		xfer && conv_irq_enable_ff && !wr_ct1 |=> conv_complete_flag_ff && CONV_IRQ)
		else $error("completion without flag or interrupt");
	deep_reset_a: assert property (@(posedge CLK)
		STOP_DEEP |=> config_register_ff == RST_BYTE && result_ff == RST_WORD
		&& state_ff == ST_IDLE && !CONV_ACTIVE)
		else $error("deep stop left registers set");
	reserved_zero_a: assert property (@(posedge CLK) disable iff (rst_all)
		rd_take && HADDR[7:0] == OFS_CTRL_TWO |=> HRDATA[3:0] == 4'h0)
		else $error("reserved control bits read nonzero");
	channel_off_a: assert property (@(posedge CLK) disable iff (rst_all)
		wr_ct1 && HWDATA[4:0] == CH_OFF |=> state_ff == ST_IDLE ##1 !seq_done)
		else $error("write with channel off did not stop converter");
	block_lost_a: assert property (@(posedge CLK) disable iff (rst_all)
		seq_done && blocked |=> !$rose(conv_complete_flag_ff) && $stable(result_ff))
		else $error("blocked result was transferred");

endmodule
`default_nettype wire

/* File: hdl/adclp_pkg.sv */
// constants, field layout and state type of the low-power converter control
package adclp_pkg;

	// ---------------------------------------------------------------
	// register byte offsets on the bus
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
	localparam logic [7:0] OFS_RES_HIGH = 8'h0c;
	localparam logic [7:0] OFS_RES_LOW = 8'h10;
	localparam logic [7:0] OFS_CMP_HIGH = 8'h14;
	localparam logic [7:0] OFS_CMP_LOW = 8'h18;
	localparam logic [7:0] OFS_PIN_ONE = 8'h1c;
	localparam logic [7:0] OFS_PIN_TWO = 8'h20;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CFG_LOW_POWER_BIT = 7;
	localparam int CFG_DIV_LSB = 5;
	localparam int CFG_LONG_BIT = 4;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_CLK_LSB = 0;
	localparam int CT2_ACTIVE_BIT = 7;
	localparam int CT2_TRIG_BIT = 6;
	localparam int CT2_CMP_EN_BIT = 5;
	localparam int CT2_CMP_GT_BIT = 4;
	localparam int CT1_CONV_COMPLETE_FLAG_BIT = 7;
	localparam int CT1_IRQ_BIT = 6;
	localparam int CT1_CONT_BIT = 5;
	localparam int CT1_CH_LSB = 0;

	// ---------------------------------------------------------------
	// encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_TEN = 2'b10;
	localparam logic [1:0] CLK_ASYNC = 2'b11;
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_WORD = 10'h000;

	// ---------------------------------------------------------------
	// conversion timing in converter clock cycles plus bus cycles
	// ---------------------------------------------------------------
	localparam logic [8:0] ADCK_SHORT_8 = 9'h014;
	localparam logic [8:0] ADCK_SHORT_10 = 9'h017;
	localparam logic [8:0] ADCK_LONG_8 = 9'h028;
	localparam logic [8:0] ADCK_LONG_10 = 9'h02b;
	localparam logic [8:0] BUS_EXTRA = 9'h005;

	// ---------------------------------------------------------------
	// converter state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01
	} adclp_state_type;

endpackage

/* File: hdl/adclp_seq.sv */
// conversion duration counter of the converter
`timescale 1ns/1ps
`default_nettype none
module adclp_seq (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic long_sample,
	input wire logic ten_bit,
	input wire logic [1:0] div,
	output logic busy,
	output logic done
);
	import adclp_pkg::*;

	logic [8:0] cnt_ff;
	logic [8:0] nxt_cnt;
	logic [8:0] base_cycles;
	logic [8:0] load_cycles;

	// ---------------------------------------------------------------
	// length of one conversion in bus cycles
	// ---------------------------------------------------------------
	assign base_cycles = long_sample ? (ten_bit ? ADCK_LONG_10 : ADCK_LONG_8)
		: (ten_bit ? ADCK_SHORT_10 : ADCK_SHORT_8);
	assign load_cycles = 9'(base_cycles << div) + BUS_EXTRA;

	// start reloads, abort clears, otherwise count down to zero
	assign busy = cnt_ff != 9'h000;
	assign done = (cnt_ff == 9'h001) & ~abort;
	assign nxt_cnt = start ? load_cycles : abort ? 9'h000 : busy ? cnt_ff - 9'h001 : cnt_ff;

	// counter register
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 9'h000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule
`default_nettype wire

/* File: dv/adclp_top_tb.sv */
// self-checking bench of the low-power converter control
`timescale 1ns/1ps
`default_nettype none
module adclp_top_tb;
	import adclp_pkg::*;
	// ---------------------------------------------------------------
	// signals and counters
	// ---------------------------------------------------------------
	logic clk, rst, hsel, hwrite, stop_sh, stop_dp, hw_trig, hreadyout, hresp, conv_irq, conv_active;
	logic low_pwr;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [9:0] ana, code, old;
	logic [4:0] chan;
	logic [15:0] pin_dis;
	logic [7:0] d, e;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	localparam logic [7:0] ADRS [10] = '{OFS_CONFIG, OFS_CTRL_TWO, OFS_CTRL_ONE, OFS_RES_HIGH,
		OFS_RES_LOW, OFS_CMP_HIGH, OFS_CMP_LOW, OFS_PIN_ONE, OFS_PIN_TWO, 8'h24};

	adclp_top DUT (.CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .STOP_SHALLOW(stop_sh), .STOP_DEEP(stop_dp),
		.HW_TRIGGER(hw_trig), .ANALOG_CODE(ana), .CONV_IRQ(conv_irq),
		.CONV_ACTIVE(conv_active), .CHANNEL_SEL(chan), .LOW_POWER(low_pwr),
		.PIN_IO_DISABLE(pin_dis));

	// ---------------------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 5000) begin
			failures++;
			end_of_test();
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] hi_of(input logic [9:0] c);
		return {30'h0, c[9:8]};
	endfunction
	function automatic logic [31:0] lo_of(input logic [9:0] c);
		return {24'h0, c[7:0]};
	endfunction
	// stored value of an 8-bit compare: code minus threshold
	function automatic logic [9:0] cmp_of(input logic [9:0] c, input logic [9:0] v);
		return {2'b00, c[9:2]} - v;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single word transfer; address held until ready, data phase until ready again
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("bus response", {31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		bus(1'b1, a, wd);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(nm, rd, exp);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (conv_irq !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic new_code();
		code = 10'($urandom);
		@(posedge clk);
		ana <= code;
	endtask
	task automatic result_check(input logic [9:0] c);
		rdchk("result high", OFS_RES_HIGH, hi_of(c));
		rdchk("result low", OFS_RES_LOW, lo_of(c));
	endtask
	task automatic reset_check();
		for (int i = 0; i < 10; i++) begin
			rdchk("reset value", ADRS[i], (ADRS[i] == OFS_CTRL_ONE) ? 32'h1f : 32'h0);
		end
		@(negedge clk);
		chk("channel out", {27'h0, chan}, 32'h1f);
		chk("pin disable", {16'h0, pin_dis}, 32'h0);
		chk("low power", {31'h0, low_pwr}, 32'h0);
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{hsel, hwrite, stop_sh, stop_dp, hw_trig} = 5'h00;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		ana = 10'h000;
		void'($urandom(91));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		reset_check();
		// random field write and read back
		repeat (8) begin
			d = 8'($urandom);
			e = 8'($urandom);
			wr(OFS_CONFIG, d);
			rdchk("config", OFS_CONFIG, {24'h0, d});
			@(negedge clk);
			chk("low power", {31'h0, low_pwr}, {31'h0, d[7]});
			wr(OFS_CTRL_TWO, {d[7:2], 2'b00});
			rdchk("control two", OFS_CTRL_TWO, {24'h0, d & 8'h70});
			wr(OFS_CMP_HIGH, d);
			rdchk("compare high", OFS_CMP_HIGH, {30'h0, d[1:0]});
			wr(OFS_CMP_LOW, e);
			rdchk("compare low", OFS_CMP_LOW, {24'h0, e});
			wr(OFS_PIN_ONE, d);
			wr(OFS_PIN_TWO, e);
			@(negedge clk);
			chk("pin disable", {16'h0, pin_dis}, {16'h0, e, d});
		end
		wr(8'h24, 8'hff);
		rdchk("unmapped", 8'h24, 32'h0);
		// single 10-bit long-sample conversion on channel 1
		wr(OFS_CONFIG, 8'h98);
		wr(OFS_CTRL_TWO, 8'h00);
		new_code();
		wr(OFS_CTRL_ONE, 8'h41);
		@(negedge clk);
		chk("active", {31'h0, conv_active}, 32'h1);
		chk("channel out", {27'h0, chan}, 32'h01);
		rdchk("active bit", OFS_CTRL_TWO, 32'h80);
		wait_irq(60);
		chk("irq", {31'h0, conv_irq}, 32'h1);
		rdchk("flag set", OFS_CTRL_ONE, 32'hc1);
		result_check(code);
		rdchk("flag clear", OFS_CTRL_ONE, 32'h41);
		// shallow stop with bus clock aborts and leaves results alone
		old = code;
		new_code();
		wr(OFS_CTRL_ONE, 8'h41);
		cycles(5);
		stop_sh <= 1'b1;
		cycles(3);
		@(negedge clk);
		chk("stop abort", {31'h0, conv_active}, 32'h0);
		cycles(60);
		chk("no completion", {31'h0, conv_irq}, 32'h0);
		@(posedge clk);
		stop_sh <= 1'b0;
		cycles(60);
		chk("idle after stop", {31'h0, conv_active}, 32'h0);
		result_check(old);
		// async clock: hardware trigger, conversion runs through shallow stop
		wr(OFS_CONFIG, 8'h0b);
		wr(OFS_CTRL_TWO, 8'h40);
		new_code();
		wr(OFS_CTRL_ONE, 8'h41);
		cycles(2);
		chk("no soft start", {31'h0, conv_active}, 32'h0);
		hw_trig <= 1'b1;
		cycles(2);
		hw_trig <= 1'b0;
		cycles(2);
		stop_sh <= 1'b1;
		wait_irq(40);
		chk("irq in stop", {31'h0, conv_irq}, 32'h1);
		result_check(code);
		wr(OFS_CTRL_TWO, 8'h00);
		wr(OFS_CTRL_ONE, 8'h41);
		cycles(3);
		chk("no soft start in stop", {31'h0, conv_active}, 32'h0);
		stop_sh <= 1'b0;
		// continuous 10-bit: a result finishing between high and low reads is lost
		wr(OFS_CONFIG, 8'h08);
		new_code();
		wr(OFS_CTRL_ONE, 8'h61);
		wait_irq(40);
		chk("irq", {31'h0, conv_irq}, 32'h1);
		rdchk("result high", OFS_RES_HIGH, hi_of(code));
		old = code;
		new_code();
		cycles(40);
		rdchk("blocked low", OFS_RES_LOW, lo_of(old));
		wait_irq(40);
		chk("irq after unblock", {31'h0, conv_irq}, 32'h1);
		result_check(code);
		// control one write restarts, channel off aborts
		wr(OFS_CTRL_ONE, 8'h41);
		cycles(10);
		wr(OFS_CTRL_ONE, 8'h42);
		@(negedge clk);
		chk("channel out", {27'h0, chan}, 32'h02);
		cycles(20);
		chk("restarted", {31'h0, conv_irq}, 32'h0);
		wait_irq(20);
		chk("restart done", {31'h0, conv_irq}, 32'h1);
		wr(OFS_CTRL_ONE, 8'h5f);
		cycles(2);
		chk("channel off abort", {31'h0, conv_active}, 32'h0);
		// deep stop returns every register to reset
		wr(OFS_PIN_ONE, 8'h02);
		wr(OFS_CONFIG, 8'h98);
		wr(OFS_CTRL_ONE, 8'h41);
		@(posedge clk);
		stop_dp <= 1'b1;
		cycles(3);
		stop_dp <= 1'b0;
		@(negedge clk);
		chk("deep stop idle", {31'h0, conv_active}, 32'h0);
		reset_check();
		// full setup again after deep stop: 8-bit conversion with greater-or-equal compare
		wr(OFS_CONFIG, 8'h00);
		wr(OFS_CMP_LOW, 8'h40);
		wr(OFS_CTRL_TWO, 8'h30);
		code = 10'($urandom) | 10'h200;
		@(posedge clk);
		ana <= code;
		wr(OFS_CTRL_ONE, 8'h41);
		wait_irq(60);
		chk("compare irq", {31'h0, conv_irq}, 32'h1);
		rdchk("8-bit high", OFS_RES_HIGH, 32'h0);
		rdchk("compare result", OFS_RES_LOW, lo_of(cmp_of(code, 10'h040)));
		// a code below the threshold ends the single conversion with nothing stored
		old = code;
		code = 10'($urandom) & 10'h0ff;
		@(posedge clk);
		ana <= code;
		wr(OFS_CTRL_ONE, 8'h41);
		cycles(40);
		chk("compare false", {31'h0, conv_irq}, 32'h0);
		chk("compare stop", {31'h0, conv_active}, 32'h0);
		rdchk("compare kept", OFS_RES_LOW, lo_of(cmp_of(old, 10'h040)));
		end_of_test();
	end
endmodule
`default_nettype wire
